// ---- spp_pkg.sv ----
package spp_pkg;

   // port geometry
   localparam int unsigned PORT_W      = 16;
   localparam int unsigned CN_W        = 24;
   localparam int unsigned SYNC_STAGES = 3;

   // bits that exist on this variant; others read as zero
   localparam logic [15:0] IMPL_MASK   = 16'hffff;
   // bits that carry an analog input function
   localparam logic [15:0] ANALOG_MASK = 16'h00ff;

   // reset values
   localparam logic [15:0] DIR_RST     = 16'hffff;
   localparam logic [15:0] LAT_RST     = 16'h0000;
   localparam logic [15:0] ODC_RST     = 16'h0000;
   localparam logic [15:0] ASEL_RST    = 16'h0000;
   localparam logic [15:0] CNEN_RST    = 16'h0000;
   localparam logic [15:0] CNPU_RST    = 16'h0000;

   // split of the change notification inputs over the two enable registers
   localparam int unsigned CN_A_W      = 16;
   localparam int unsigned CN_B_W      = 8;

   // software write targets for the output latch
   typedef enum logic [1:0] {
      SPP_WR_NONE,
      SPP_WR_LATCH,
      SPP_WR_PINREG
   } spp_wr_t;

endpackage : spp_pkg

// ---- spp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; output changes once stages two and three agree
module spp_sync #(
   parameter int unsigned W = 16
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         srst,
   // data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   ////////////////////////////////////////////////////////////////////////
   // stage one is read by stage two only
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stage1   <= '0;
         stage2   <= '0;
         stage3   <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         // agreement filter rejects a single-cycle glitch
         for (int i = 0; i < W; i++) begin
            if (stage2[i] == stage3[i]) begin
               sync_out[i] <= stage3[i];
            end
         end
      end
   end

endmodule : spp_sync

`default_nettype wire

// ---- spp_change_notify.sv ----
`timescale 1ns/1ps
`default_nettype none

// change-of-state detector on synchronised change notification inputs
module spp_change_notify (
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       srst,
   // inputs and enables
   input  wire logic [spp_pkg::CN_W-1:0]   cn_level,
   input  wire logic [spp_pkg::CN_W-1:0]   cn_enable,
   // result
   output logic                            cn_change
);

   logic [spp_pkg::CN_W-1:0] prev_level;
   logic                     primed;

   ////////////////////////////////////////////////////////////////////////
   // previous sample; first cycle after reset only primes, no false event
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prev_level <= '0;
         primed     <= 1'b0;
         cn_change  <= 1'b0;
      end else begin
         prev_level <= cn_level;
         primed     <= 1'b1;
         cn_change  <= primed && (|((cn_level ^ prev_level) & cn_enable));
      end
   end

endmodule : spp_change_notify

`default_nettype wire

// ---- spp_port.sv ----
`timescale 1ns/1ps
`default_nettype none

module spp_port (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // software access: write strobes and data
   input  wire logic        dir_wr,
   input  wire logic        latch_wr,
   input  wire logic        pinreg_wr,
   input  wire logic        odc_wr,
   input  wire logic        asel1_wr,
   input  wire logic        asel2_wr,
   input  wire logic        cnen_a_wr,
   input  wire logic        cnen_b_wr,
   input  wire logic        cnpu_a_wr,
   input  wire logic        cnpu_b_wr,
   input  wire logic [15:0] wr_data,
   // software access: read values
   output logic      [15:0] pin_direction_reg,
   output logic      [15:0] output_latch_reg,
   output logic      [15:0] pin_level_reg,
   output logic      [15:0] open_drain_ctrl_reg,
   output logic      [15:0] analog_select_low_reg,
   output logic      [15:0] analog_select_high_reg,
   output logic      [15:0] change_irq_enable_reg_a,
   output logic      [7:0]  change_irq_enable_reg_b,
   output logic      [15:0] weak_pullup_enable_reg_a,
   output logic      [7:0]  weak_pullup_enable_reg_b,
   // peripheral sharing
   input  wire logic [15:0] periph_drive,
   input  wire logic [15:0] periph_out,
   input  wire logic [15:0] periph_od,
   output logic      [15:0] periph_in,
   // package pins
   input  wire logic [15:0] pin_in,
   output logic      [15:0] pin_out,
   output logic      [15:0] pin_oe,
   output logic      [15:0] analog_mode,
   // change notification
   input  wire logic [23:0] change_notify_input,
   output logic      [23:0] pullup_on,
   output logic             change_irq
);

   logic [15:0] dir_q;
   logic [15:0] lat_q;
   logic [15:0] odc_q;
   logic [15:0] asel1_q;
   logic [15:0] asel2_q;
   logic [15:0] cnen_a_q;
   logic [7:0]  cnen_b_q;
   logic [15:0] cnpu_a_q;
   logic [7:0]  cnpu_b_q;
   logic [15:0] pin_sync;
   logic [23:0] cn_sync;
   logic        cn_change;
   logic [15:0] is_analog;
   logic [15:0] next_pin_out;
   logic [15:0] next_pin_oe;
   spp_pkg::spp_wr_t lat_src;
   // pad-to-periph_in latency plus margin; sizes the loop-through guard
   localparam int unsigned HOLD   = spp_pkg::SYNC_STAGES + 3;
   // edges until the change synchronisers hold real levels after reset
   localparam logic [2:0]  SETTLE = 3'(spp_pkg::SYNC_STAGES + 2);
   logic [15:0] own_now;
   logic [15:0] own_recent;
   logic [15:0] own_hist [HOLD];
   logic [2:0]  settle_cnt;
   logic [23:0] cn_en_live;

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers for pins and change notification lines
   spp_sync #(
      .W (spp_pkg::PORT_W)
   ) u_pin_sync (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   spp_sync #(
      .W (spp_pkg::CN_W)
   ) u_cn_sync (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .async_in (change_notify_input),
      .sync_out (cn_sync)
   );

   spp_change_notify u_cn (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .cn_level  (cn_sync),
      .cn_enable (cn_en_live),
      .cn_change (cn_change)
   );

   ////////////////////////////////////////////////////////////////////////
   // direction register, all inputs after reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dir_q <= spp_pkg::DIR_RST & spp_pkg::IMPL_MASK;
      end else if (dir_wr) begin
         dir_q <= wr_data & spp_pkg::IMPL_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // latch source: both the latch and the pin register write the latch
   always_comb begin
      if (latch_wr) begin
         lat_src = spp_pkg::SPP_WR_LATCH;
      end else if (pinreg_wr) begin
         lat_src = spp_pkg::SPP_WR_PINREG;
      end else begin
         lat_src = spp_pkg::SPP_WR_NONE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lat_q <= spp_pkg::LAT_RST;
      end else begin
         unique case (lat_src)
            spp_pkg::SPP_WR_LATCH:  lat_q <= wr_data & spp_pkg::IMPL_MASK;
            spp_pkg::SPP_WR_PINREG: lat_q <= wr_data & spp_pkg::IMPL_MASK;
            spp_pkg::SPP_WR_NONE:   lat_q <= lat_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // open-drain control
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         odc_q <= spp_pkg::ODC_RST;
      end else if (odc_wr) begin
         odc_q <= wr_data & spp_pkg::IMPL_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // analog select, one copy per converter; only analog-capable bits clear
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         asel1_q <= spp_pkg::ASEL_RST | ~spp_pkg::ANALOG_MASK;
         asel2_q <= spp_pkg::ASEL_RST | ~spp_pkg::ANALOG_MASK;
      end else begin
         if (asel1_wr) begin
            asel1_q <= wr_data | ~spp_pkg::ANALOG_MASK;
         end
         if (asel2_wr) begin
            asel2_q <= wr_data | ~spp_pkg::ANALOG_MASK;
         end
      end
   end

   // either converter claiming the pin makes it analog
   assign is_analog = ~(asel1_q & asel2_q) & spp_pkg::ANALOG_MASK;

   ////////////////////////////////////////////////////////////////////////
   // change enable and pull-up registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnen_a_q <= spp_pkg::CNEN_RST;
         cnen_b_q <= spp_pkg::CNEN_RST[7:0];
         cnpu_a_q <= spp_pkg::CNPU_RST;
         cnpu_b_q <= spp_pkg::CNPU_RST[7:0];
      end else begin
         if (cnen_a_wr) begin
            cnen_a_q <= wr_data;
         end
         if (cnen_b_wr) begin
            cnen_b_q <= wr_data[7:0];
         end
         if (cnpu_a_wr) begin
            cnpu_a_q <= wr_data;
         end
         if (cnpu_b_wr) begin
            cnpu_b_q <= wr_data[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start-up hold-off: synchronisers leave reset at zero and climb to the
   // real levels a few edges later, which would otherwise look like a change
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         settle_cnt <= '0;
      end else if (settle_cnt != SETTLE) begin
         settle_cnt <= settle_cnt + 3'h1;
      end
   end

   // enables reach the detector only once the synchronisers hold real levels
   assign cn_en_live = (settle_cnt == SETTLE) ? {cnen_b_q, cnen_a_q} : 24'h000000;

   ////////////////////////////////////////////////////////////////////////
   // output mux: peripheral owns the pin only while actively driving
   always_comb begin
      next_pin_out = '0;
      next_pin_oe  = '0;
      for (int i = 0; i < 16; i++) begin
         if (periph_drive[i]) begin
            // port driver disabled for this bit
            next_pin_out[i] = periph_out[i];
            next_pin_oe[i]  = periph_od[i] ? ~periph_out[i] : 1'b1;
         end else if (!dir_q[i]) begin
            // port drives; idle peripherals leave the pin to it
            if (odc_q[i]) begin
               next_pin_out[i] = 1'b0;
               next_pin_oe[i]  = ~lat_q[i];
            end else begin
               next_pin_out[i] = lat_q[i];
               next_pin_oe[i]  = 1'b1;
            end
         end
      end
      next_pin_out = next_pin_out & spp_pkg::IMPL_MASK;
      next_pin_oe  = next_pin_oe & spp_pkg::IMPL_MASK;
   end

   ////////////////////////////////////////////////////////////////////////
   // loop-through guard: a pad level takes several edges to reach
   // periph_in, so a bit the port has just released stays masked until its
   // own drive has drained out of the synchronisers
   assign own_now = next_pin_oe & ~periph_drive;

   // drive history, one stage per entry
   for (genvar gh = 0; gh < HOLD; gh++) begin : g_own_hist
      if (gh == 0) begin : g_head
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               own_hist[gh] <= '0;
            end else begin
               own_hist[gh] <= own_now;
            end
         end
      end else begin : g_tail
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               own_hist[gh] <= '0;
            end else begin
               own_hist[gh] <= own_hist[gh-1];
            end
         end
      end
   end

   // any recent port drive keeps the bit away from the peripherals
   always_comb begin
      own_recent = own_now;
      for (int h = 0; h < HOLD; h++) begin
         own_recent = own_recent | own_hist[h];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered pin drive and readback; a direction change shows one cycle
   // later, so software must pause before reading the port
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_out       <= '0;
         pin_oe        <= '0;
         periph_in     <= '0;
         pin_level_reg <= '0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe  <= next_pin_oe;
         // peripherals see the synchronised pad, never the port's own drive
         // on an owned bit; input-only users are treated as plain inputs
         periph_in     <= pin_sync & ~own_recent;
         pin_level_reg <= pin_sync & ~is_analog & spp_pkg::IMPL_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register readback and side outputs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_direction_reg        <= spp_pkg::DIR_RST & spp_pkg::IMPL_MASK;
         output_latch_reg         <= '0;
         open_drain_ctrl_reg      <= '0;
         analog_select_low_reg    <= '0;
         analog_select_high_reg   <= '0;
         change_irq_enable_reg_a  <= '0;
         change_irq_enable_reg_b  <= '0;
         weak_pullup_enable_reg_a <= '0;
         weak_pullup_enable_reg_b <= '0;
         analog_mode              <= '0;
         pullup_on                <= '0;
         change_irq               <= 1'b0;
      end else begin
         pin_direction_reg        <= dir_q;
         output_latch_reg         <= lat_q;
         open_drain_ctrl_reg      <= odc_q;
         analog_select_low_reg    <= asel1_q;
         analog_select_high_reg   <= asel2_q;
         change_irq_enable_reg_a  <= cnen_a_q;
         change_irq_enable_reg_b  <= cnen_b_q;
         weak_pullup_enable_reg_a <= cnpu_a_q;
         weak_pullup_enable_reg_b <= cnpu_b_q;
         analog_mode              <= is_analog;
         pullup_on                <= {cnpu_b_q, cnpu_a_q};
         change_irq               <= cn_change;
      end
   end

endmodule : spp_port

`default_nettype wire

// ---- spp_port_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// port-side checker; sees only the top module's ports
module spp_port_sva (
   // clock, reset, write strobes and change request
   input wire logic        sys_clk, srst, dir_wr, latch_wr, pinreg_wr, change_irq,
   // data, readback, peripheral and pin buses
   input wire logic [15:0] wr_data, pin_direction_reg, output_latch_reg, pin_level_reg,
   input wire logic [15:0] open_drain_ctrl_reg, analog_select_low_reg, analog_select_high_reg,
   input wire logic [15:0] change_irq_enable_reg_a, weak_pullup_enable_reg_a, periph_drive,
   input wire logic [15:0] periph_out, periph_od, periph_in, pin_in, pin_out, pin_oe,
   input wire logic [15:0] analog_mode,
   input wire logic [7:0]  change_irq_enable_reg_b, weak_pullup_enable_reg_b,
   input wire logic [23:0] change_notify_input, pullup_on
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////
   logic [3:0]  up;
   logic [15:0] pm, om;
   // settle counter; keeps synchroniser start-up out of the level checks
   always_ff @(posedge sys_clk) begin
      if (srst) up <= 4'h0;
      else if (up != 4'hf) up <= up + 4'h1;
   end
   // port-owned push-pull and open-drain bits
   assign pm = ~periph_drive & ~open_drain_ctrl_reg;
   assign om = ~periph_drive & open_drain_ctrl_reg & ~pin_direction_reg;
   sequence s_calm;
      (up == 4'hf && $stable({periph_drive, periph_out, periph_od, pin_direction_reg,
         output_latch_reg, open_drain_ctrl_reg, analog_mode, analog_select_low_reg,
         analog_select_high_reg, weak_pullup_enable_reg_a, weak_pullup_enable_reg_b}))[*3];
   endsequence
   sequence s_pins;
      (up == 4'hf && $stable(pin_in) && $stable(analog_mode))[*6];
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   property p_dir;
      dir_wr |-> ##2 pin_direction_reg == ($past(wr_data, 2) & spp_pkg::IMPL_MASK);
   endproperty
   property p_lat;
      latch_wr |-> ##2 output_latch_reg == ($past(wr_data, 2) & spp_pkg::IMPL_MASK);
   endproperty
   property p_pinreg;
      pinreg_wr && !latch_wr |-> ##2 output_latch_reg == ($past(wr_data, 2) & spp_pkg::IMPL_MASK);
   endproperty
   property p_own;
      s_calm |-> ((pin_oe ^ (~periph_od | ~periph_out)) & periph_drive) == 16'h0000
         && ((pin_out ^ periph_out) & periph_drive & pin_oe) == 16'h0000;
   endproperty
   property p_port;
      s_calm |-> ((pin_oe ^ ~pin_direction_reg) & pm) == 16'h0000
         && ((pin_out ^ output_latch_reg) & pm & pin_oe) == 16'h0000;
   endproperty
   property p_od;
      s_calm |-> ((pin_oe ^ ~output_latch_reg) & om) == 16'h0000
         && (pin_out & om & pin_oe) == 16'h0000;
   endproperty
   property p_loop;
      s_calm |-> (periph_in & pin_oe & ~periph_drive) == 16'h0000;
   endproperty
   property p_ana;
      s_calm |-> analog_mode
         == (~(analog_select_low_reg & analog_select_high_reg) & spp_pkg::ANALOG_MASK);
   endproperty
   property p_lvl;
      s_pins |-> pin_level_reg == (pin_in & ~analog_mode & spp_pkg::IMPL_MASK);
   endproperty
   property p_irq;
      up == 4'hf && (($past(change_notify_input) ^ change_notify_input)
         & {change_irq_enable_reg_b, change_irq_enable_reg_a}) != 24'h000000
         |-> ##[2:9] change_irq;
   endproperty
   property p_pu;
      s_calm |-> pullup_on == {weak_pullup_enable_reg_b, weak_pullup_enable_reg_a};
   endproperty
   ////////////////////////////////////////////////////////////////////////////
   a_dir: assert property (p_dir) else $error("direction readback wrong");
   a_lat: assert property (p_lat) else $error("latch readback wrong");
   a_pinreg: assert property (p_pinreg) else $error("pin register write missed latch");
   a_own: assert property (p_own) else $error("peripheral does not own pin");
   a_port: assert property (p_port) else $error("port drive wrong");
   a_od: assert property (p_od) else $error("open-drain drive wrong");
   a_loop: assert property (p_loop) else $error("port output loops to peripheral");
   a_ana: assert property (p_ana) else $error("analog mode wrong");
   a_lvl: assert property (p_lvl) else $error("pin level wrong");
   a_irq: assert property (p_irq) else $error("change request missing");
   a_pu: assert property (p_pu) else $error("pull-up enable wrong");
endmodule : spp_port_sva
`default_nettype wire

// ---- spp_pins_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// package pins with an outside driver; port driver wins any contest
module spp_pins_model (
   input wire logic        sys_clk,
   input wire logic [15:0] pin_out, pin_oe, ext_en, ext_val,
   output logic     [15:0] pin_in
);
   logic [15:0] last;
   // a floating pin never keeps its old level, so stale reads show up
   always_ff @(posedge sys_clk) last <= pin_in;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & ~last);
endmodule : spp_pins_model
`default_nettype wire

// ---- spp_port_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module spp_port_tb_top;
   logic        sys_clk = 1'b0, srst = 1'b1, change_irq;
   logic [9:0]  stb = 10'h000;
   logic [15:0] wr_data = 16'h0000, periph_drive = 16'h0000, periph_out = 16'h0000;
   logic [15:0] periph_od = 16'h0000, ext_val = 16'ha5c3;
   logic [15:0] pin_direction_reg, output_latch_reg, pin_level_reg, open_drain_ctrl_reg;
   logic [15:0] analog_select_low_reg, analog_select_high_reg, change_irq_enable_reg_a;
   logic [15:0] weak_pullup_enable_reg_a, periph_in, pin_in, pin_out, pin_oe, analog_mode;
   logic [7:0]  change_irq_enable_reg_b, weak_pullup_enable_reg_b;
   logic [23:0] change_notify_input = 24'h000000, pullup_on;
   int          bad_count = 0, checks = 0, n;
   always #5 sys_clk = ~sys_clk;
   spp_port dut_u (.*, .dir_wr(stb[0]), .latch_wr(stb[1]), .pinreg_wr(stb[2]), .odc_wr(stb[3]),
      .asel1_wr(stb[4]), .asel2_wr(stb[5]), .cnen_a_wr(stb[6]), .cnen_b_wr(stb[7]),
      .cnpu_a_wr(stb[8]), .cnpu_b_wr(stb[9]));
   spp_pins_model pins_u (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .ext_en(16'hffff), .ext_val(ext_val), .pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one-cycle strobe, then a long gap so pins resync before reading back
   task automatic wr(input int k, input logic [15:0] d);
      @(negedge sys_clk);
      stb[k] = 1'b1;
      wr_data = d;
      @(negedge sys_clk);
      stb[k] = 1'b0;
      repeat (7) @(negedge sys_clk);
   endtask : wr
   task automatic cn_flip(input int b, input int exp);
      @(negedge sys_clk);
      change_notify_input[b] = ~change_notify_input[b];
      n = 0;
      repeat (12) begin
         @(negedge sys_clk);
         if (change_irq === 1'b1) n++;
      end
      chk(24'(n), 24'(exp));
   endtask : cn_flip
   task automatic periph(input logic [15:0] d, input logic [15:0] o, input logic [15:0] od);
      @(negedge sys_clk);
      periph_drive = d;
      periph_out = o;
      periph_od = od;
      repeat (7) @(negedge sys_clk);
   endtask : periph
   task automatic results();
      $display("checks=%0d mismatches=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////////
   // watchdog; whole sequence needs well under a thousand cycles
   initial begin
      #20000;
      bad_count++;
      results();
   end
   initial begin
      repeat (2) @(negedge sys_clk);
      srst = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk(pin_direction_reg, 16'hffff);
      chk(pin_oe, 16'h0000);
      chk(analog_mode, spp_pkg::ANALOG_MASK);
      $display("reset test done");
      wr(4, 16'hffff);
      wr(5, 16'hffff);
      chk(analog_mode, 16'h0000);
      wr(1, 16'h1234);
      chk(output_latch_reg, 16'h1234);
      wr(0, 16'hff00);
      chk(pin_oe, 16'h00ff);
      chk(pin_out & 16'h00ff, 16'h0034);
      chk(pin_level_reg, 16'ha534);
      wr(2, 16'h00aa);
      chk(output_latch_reg, 16'h00aa);
      chk(output_latch_reg & ~spp_pkg::IMPL_MASK, 16'h0000);
      wr(3, 16'h000f);
      chk(pin_oe, 16'h00f5);
      chk(pin_out & 16'h0005, 16'h0000);
      chk(open_drain_ctrl_reg, 16'h000f);
      wr(3, 16'h0000);
      $display("port test done");
      periph(16'h0103, 16'h0101, 16'h0000);
      chk(pin_oe, 16'h01ff);
      chk(pin_out & 16'h0103, 16'h0101);
      chk(pin_level_reg & 16'h0103, 16'h0101);
      chk(periph_in & 16'hfefc, 16'ha400);
      periph(16'h0004, 16'h0004, 16'h0004);
      chk(pin_oe, 16'h00fb);
      periph(16'h0000, 16'h0004, 16'h0004);
      chk(pin_oe, 16'h00ff);
      $display("peripheral test done");
      wr(0, 16'hffff);
      wr(4, 16'hfff0);
      chk(analog_mode, 16'h000f);
      chk(pin_level_reg & 16'h00ff, 16'h00c0);
      wr(4, 16'hffff);
      wr(5, 16'hff0f);
      chk(analog_mode, 16'h00f0);
      chk(analog_select_high_reg, 16'hff0f);
      chk(pin_level_reg & 16'h00ff, 16'h0003);
      $display("analog test done");
      wr(6, 16'h0001);
      wr(7, 16'h0080);
      // pull-ups follow the enable registers whatever the pin directions
      wr(8, 16'h00f0);
      wr(9, 16'h0001);
      chk(pullup_on, 24'h0100f0);
      chk({change_irq_enable_reg_b, change_irq_enable_reg_a}, 24'h800001);
      cn_flip(0, 1);
      cn_flip(23, 1);
      cn_flip(5, 0);
      $display("change test done");
      results();
   end
endmodule : spp_port_tb_top
bind spp_port spp_port_sva chk_u (.*);
`default_nettype wire
